// >>> verilog/ppc_cfg.svh
// Register indices, address width, reset values and masks for the port configuration registers
// Functional notes
// - Mode field 00/01/10/11 selects uni8, uni16, bidir8, bidir16 port operation.
// - Two enable bits gate handshake logic of first and second port pairs.
// - Each sense bit sets one handshake pin polarity; one means active high.
// - Reset clears general control and service request registers; both always accessible.
// - Top bit of service request register reads zero and ignores writes.
// - Select 0X leaves shared DMA pin as port C; no DMA requests.
// - Select 10 gives DMA pulses from line one, gated by port A control bit 1.
// - Select 11 gives DMA pulses from line three, gated by port B control bit 1.
// - Pin select 00 keeps both pins port C; 01 makes request pin autovector request.
// - Pin select 10 makes only acknowledge active; 11 makes both active for vectoring.
// - Priority field: bit 2 puts pair three/four first; bits 0,1 swap within pairs.
// - Port A direction bits: zero input, one output; reset to input.
// - Port A direction ignored in mode 3; port B direction ignored in modes 2, 3.
// - Port C direction is 8-bit, mode independent, cleared on reset.
// - Vector register holds upper six vector bits; read normally or during acknowledge.
// - Before any write after reset, a normal vector read returns 0x0F.
// - After a write, vector read returns stored six bits with low two bits zero.
// - Normal vector read has no side effect and no priority evaluation.
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

`define PPC_IDX_GEN_CTRL  3'h0
`define PPC_IDX_SVC_REQ   3'h1
`define PPC_IDX_A_DIR     3'h2
`define PPC_IDX_B_DIR     3'h3
`define PPC_IDX_C_DIR     3'h4
`define PPC_IDX_VECTOR    3'h5
`define PPC_ADDR_W        5
`define PPC_RST_BYTE      8'h00
`define PPC_RST_VEC_READ  8'h0F
`define PPC_RST_VEC_UPPER 6'h03
`define PPC_SVC_REQ_MASK  8'h7F
`define PPC_VEC_LOW_ZERO  2'h0

`endif

// >>> verilog/ppc_pkg.sv
// Types for the port configuration register block
package ppc_pkg;

    // Port mode field values
    typedef enum logic [1:0] {
        PPC_MODE_UNI8,
        PPC_MODE_UNI16,
        PPC_MODE_BIDIR8,
        PPC_MODE_BIDIR16
    } ppc_mode_t;

    // General control register layout
    typedef struct packed {
        ppc_mode_t  mode;
        logic       second_pair_handshake_enable;
        logic       first_pair_handshake_enable;
        logic [3:0] sense;
    } ppc_gen_ctrl_t;

    // Service request register layout
    typedef struct packed {
        logic       unused;
        logic [1:0] service_request_select;
        logic [1:0] irq_pin_select;
        logic [2:0] priority_sel;
    } ppc_svc_req_t;

    // Handshake configuration seen by the port logic
    typedef struct packed {
        ppc_mode_t  mode;
        logic       first_pair_handshake_enable;
        logic       second_pair_handshake_enable;
        logic [3:0] sense;
    } ppc_hs_cfg_t;

    // Dual-function pin roles
    typedef struct packed {
        logic shared_dma_request_pin_active;
        logic shared_port_irq_pin_active;
        logic shared_port_ack_pin_active;
    } ppc_pin_role_t;

endpackage

// >>> verilog/ppc_regs.sv
// Port configuration register bank with APB slave, DMA and port interrupt routing
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "ppc_cfg.svh"

module ppc_regs
    import ppc_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          sys_rst,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Control bits of the port control registers
    input  wire logic          port_a_control_svcrq_enable,
    input  wire logic          port_b_control_svcrq_enable,
    // Handshake status sources, one per line, active high
    input  wire logic [3:0]    handshake_status,
    // Per-source interrupt enables from the port control registers
    input  wire logic [3:0]    handshake_irq_enable,
    // Double-buffered transfer events on lines one and three
    input  wire logic          handshake_one_transfer,
    input  wire logic          handshake_three_transfer,
    // Logical assertion wanted on each handshake pin
    input  wire logic [3:0]    handshake_assert,
    // Raw handshake pin levels
    input  wire logic [3:0]    handshake_pin_level,
    // Interrupt acknowledge strobe from the acknowledge pin
    input  wire logic          port_ack,
    output ppc_hs_cfg_t        hs_cfg,
    output logic [3:0]         handshake_pin_out,
    output logic [3:0]         handshake_pin_asserted,
    output ppc_pin_role_t      pin_role,
    output logic               dma_request,
    output logic               port_irq,
    output logic [7:0]         ack_vector,
    output logic               ack_vector_valid,
    output logic [7:0]         port_a_dir,
    output logic               port_a_dir_used,
    output logic [7:0]         port_b_dir,
    output logic               port_b_dir_used,
    output logic [7:0]         port_c_dir
);

    // Register state
    ppc_gen_ctrl_t port_general_control;
    ppc_svc_req_t  port_service_request_control;
    logic [7:0]    port_a_direction;
    logic [7:0]    port_b_direction;
    logic [7:0]    port_c_direction;
    logic [5:0]    vector_upper;
    logic          vector_written;

    // Rank of the four sources, highest first, per priority setting
    function automatic logic [7:0] rank_order(input logic [2:0] sel);
        logic [3:0] lo_pair;
        logic [3:0] hi_pair;
        lo_pair = sel[0] ? {2'd1, 2'd0} : {2'd0, 2'd1};
        hi_pair = sel[1] ? {2'd3, 2'd2} : {2'd2, 2'd3};
        rank_order = sel[2] ? {hi_pair, lo_pair} : {lo_pair, hi_pair};
    endfunction

    // Register select from a word address
    function automatic logic hit(input logic [7:0] addr, input logic [2:0] idx);
        hit = (addr[7:2] == {3'h0, idx}) && (addr[1:0] == 2'h0);
    endfunction

    // APB decode
    wire       setup_phase = psel && !penable;
    wire       wr_access   = psel && penable && pwrite && pstrb[0];
    wire       sel_gen     = hit(paddr, `PPC_IDX_GEN_CTRL);
    wire       sel_svc     = hit(paddr, `PPC_IDX_SVC_REQ);
    wire       sel_adir    = hit(paddr, `PPC_IDX_A_DIR);
    wire       sel_bdir    = hit(paddr, `PPC_IDX_B_DIR);
    wire       sel_cdir    = hit(paddr, `PPC_IDX_C_DIR);
    wire       sel_vec     = hit(paddr, `PPC_IDX_VECTOR);
    wire       mapped      = sel_gen | sel_svc | sel_adir | sel_bdir | sel_cdir | sel_vec;
    wire [7:0] wbyte       = pwdata[7:0];

    // Vector read value: fixed until first write, then low bits forced zero
    wire [7:0] vector_read = vector_written ? {vector_upper, `PPC_VEC_LOW_ZERO}
                                            : `PPC_RST_VEC_READ;

    // Read mux, no side effects on any state
    wire [7:0] read_byte =
        sel_gen  ? port_general_control :
        sel_svc  ? (port_service_request_control & `PPC_SVC_REQ_MASK) :
        sel_adir ? port_a_direction :
        sel_bdir ? port_b_direction :
        sel_cdir ? port_c_direction :
        sel_vec  ? vector_read : `PPC_RST_BYTE;

    // Answer in the access phase, data captured at setup
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !mapped;

    // Read data register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata <= {24'h00_0000, read_byte};
        end
    end

    // General and service request registers, cleared by reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            port_general_control         <= `PPC_RST_BYTE;
            port_service_request_control <= `PPC_RST_BYTE;
        end else if (wr_access) begin
            if (sel_gen) begin
                port_general_control <= wbyte;
            end
            if (sel_svc) begin
                port_service_request_control <= wbyte & `PPC_SVC_REQ_MASK;
            end
        end
    end

    // Direction registers, input state after reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            port_a_direction <= `PPC_RST_BYTE;
            port_b_direction <= `PPC_RST_BYTE;
            port_c_direction <= `PPC_RST_BYTE;
        end else if (wr_access) begin
            if (sel_adir) begin
                port_a_direction <= wbyte;
            end
            if (sel_bdir) begin
                port_b_direction <= wbyte;
            end
            if (sel_cdir) begin
                port_c_direction <= wbyte;
            end
        end
    end

    // Vector register upper bits and written flag
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            vector_upper   <= `PPC_RST_VEC_UPPER;
            vector_written <= 1'b0;
        end else if (wr_access && sel_vec) begin
            vector_upper   <= wbyte[7:2];
            vector_written <= 1'b1;
        end
    end

    // Mode decode
    wire ppc_mode_t mode      = port_general_control.mode;
    wire            is_bidir  = (mode == PPC_MODE_BIDIR8) || (mode == PPC_MODE_BIDIR16);
    wire            is_bid16  = (mode == PPC_MODE_BIDIR16);

    // Handshake configuration to the port logic
    assign hs_cfg.mode                         = mode;
    assign hs_cfg.first_pair_handshake_enable  =
        port_general_control.first_pair_handshake_enable;
    assign hs_cfg.second_pair_handshake_enable =
        port_general_control.second_pair_handshake_enable;
    assign hs_cfg.sense                        = port_general_control.sense;

    // Pair enables per handshake line
    wire [3:0] line_enable = {{2{port_general_control.second_pair_handshake_enable}},
                              {2{port_general_control.first_pair_handshake_enable}}};

    // Pin polarity: sense one means high when asserted
    wire [3:0] sense = port_general_control.sense;
    wire [3:0] next_pin_out = (handshake_assert & line_enable) ~^ sense;
    // Reset level: sense clear, nothing asserted, so every pin sits high
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            handshake_pin_out      <= 4'hF;
            handshake_pin_asserted <= 4'h0;
        end else begin
            handshake_pin_out      <= next_pin_out;
            handshake_pin_asserted <= ~(handshake_pin_level ^ sense);
        end
    end

    // Service request and interrupt pin selects
    wire [1:0] svc_sel   = port_service_request_control.service_request_select;
    wire [1:0] irq_sel   = port_service_request_control.irq_pin_select;
    wire       dma_on    = svc_sel[1];
    wire       dma_line1 = dma_on && !svc_sel[0];
    wire       dma_line3 = dma_on && svc_sel[0];

    // Dual-function pin roles
    assign pin_role.shared_dma_request_pin_active = dma_on;
    assign pin_role.shared_port_irq_pin_active    = irq_sel[0];
    assign pin_role.shared_port_ack_pin_active    = irq_sel[1];

    // DMA request pulse from the selected line
    wire next_dma = (dma_line1 && port_a_control_svcrq_enable
                     && handshake_one_transfer && line_enable[0])
                 || (dma_line3 && port_b_control_svcrq_enable
                     && handshake_three_transfer && line_enable[2]);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dma_request <= 1'b0;
        end else begin
            dma_request <= next_dma;
        end
    end

    // Interrupt sources, lines used for DMA removed
    wire [3:0] dma_mask = {1'b0, dma_line3, 1'b0, dma_line1};
    wire [3:0] pending  = handshake_status & handshake_irq_enable & line_enable & ~dma_mask;

    // Priority selection over the ranked sources
    wire [7:0] order = rank_order(port_service_request_control.priority_sel);
    logic [1:0] winner;
    always_comb begin
        winner = order[7:6];
        for (int i = 0; i < 4; i++) begin
            if (pending[order[2*i +: 2]]) begin
                winner = order[2*i +: 2];
            end
        end
    end

    // Request output and acknowledge vector
    wire any_pending = |pending;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            port_irq         <= 1'b0;
            ack_vector       <= `PPC_RST_BYTE;
            ack_vector_valid <= 1'b0;
        end else begin
            port_irq         <= any_pending && irq_sel[0];
            ack_vector_valid <= port_ack && irq_sel[1] && any_pending;
            if (port_ack && irq_sel[1] && any_pending) begin
                ack_vector <= {vector_upper, winner};
            end
        end
    end

    // Direction outputs, ignored in the bidirectional modes noted
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            port_a_dir      <= `PPC_RST_BYTE;
            port_a_dir_used <= 1'b1;
            port_b_dir      <= `PPC_RST_BYTE;
            port_b_dir_used <= 1'b1;
            port_c_dir      <= `PPC_RST_BYTE;
        end else begin
            port_a_dir      <= port_a_direction;
            port_a_dir_used <= !is_bid16;
            port_b_dir      <= port_b_direction;
            port_b_dir_used <= !is_bidir;
            port_c_dir      <= port_c_direction;
        end
    end

endmodule

// >>> bench/ppc_regs_monitor.sv
// Concurrent checks on the port configuration register block ports
`timescale 1ns/10ps

module ppc_regs_monitor
    import ppc_pkg::*;
(
    input logic          clock,
    input logic          sys_rst,
    input logic          psel,
    input logic          penable,
    input logic          pwrite,
    input logic [7:0]    paddr,
    input logic [31:0]   prdata,
    input logic          pslverr,
    input ppc_pin_role_t pin_role,
    input logic          dma_request,
    input logic          port_irq,
    input logic          port_ack,
    input logic          ack_vector_valid,
    input ppc_hs_cfg_t   hs_cfg,
    input logic          port_a_dir_used,
    input logic          port_b_dir_used,
    input logic [3:0]    handshake_pin_level,
    input logic [3:0]    handshake_pin_asserted
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Access phase qualifiers
    wire acc = psel && penable;
    wire rd  = acc && !pwrite;

    // Bus decode and read values
    property p_unmap; acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h14); endproperty
    a_unmap: assert property (p_unmap) else $error("pslverr wrong");
    property p_svc_top; rd && paddr == 8'h04 |-> prdata[7] == 1'b0; endproperty
    a_svc_top: assert property (p_svc_top) else $error("service bit 7 set");
    property p_vec_low; rd && paddr == 8'h14 |-> prdata[1:0] == 2'h0 || prdata[7:0] == 8'h0F;
    endproperty
    a_vec_low: assert property (p_vec_low) else $error("vector low bits");

    // Pin functions follow the service request choices
    property p_dma_off; !pin_role.shared_dma_request_pin_active |=> !dma_request; endproperty
    a_dma_off: assert property (p_dma_off) else $error("dma without select");
    property p_irq_pin; port_irq |-> $past(pin_role.shared_port_irq_pin_active); endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("irq on port pin");
    property p_ack;
        ack_vector_valid |-> $past(port_ack) && $past(pin_role.shared_port_ack_pin_active);
    endproperty
    a_ack: assert property (p_ack) else $error("vector without ack");

    // Direction use and handshake sense
    property p_a_used;
        !$past(sys_rst) |-> port_a_dir_used == ($past(hs_cfg.mode) != PPC_MODE_BIDIR16);
    endproperty
    a_a_used: assert property (p_a_used) else $error("port a dir use");
    property p_b_used; !$past(sys_rst) |-> port_b_dir_used == !$past(hs_cfg.mode[1]); endproperty
    a_b_used: assert property (p_b_used) else $error("port b dir use");
    property p_sense;
        !$past(sys_rst) |->
            handshake_pin_asserted == ($past(handshake_pin_level) ~^ $past(hs_cfg.sense));
    endproperty
    a_sense: assert property (p_sense) else $error("pin sense in");

    // Main scenarios reached
    c_dma: cover property (dma_request);
    c_ack: cover property (ack_vector_valid);
    c_err: cover property (pslverr);
endmodule

bind ppc_regs ppc_regs_monitor u_ppc_mon (
    .clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr, .pin_role,
    .dma_request, .port_irq, .port_ack, .ack_vector_valid, .hs_cfg, .port_a_dir_used,
    .port_b_dir_used, .handshake_pin_level, .handshake_pin_asserted
);

// >>> bench/ppc_host_model.sv
// Host side interrupt acknowledge model
`timescale 1ns/10ps

module ppc_host_model (
    input  logic       clock,
    input  logic       sys_rst,
    input  logic       ack_en,
    input  logic [3:0] ack_delay,
    input  logic       port_irq,
    input  logic       ack_vector_valid,
    input  logic [7:0] ack_vector,
    output logic       port_ack,
    output logic       seen,
    output logic [7:0] last_vec
);
    logic [3:0] wait_cnt;
    logic       busy;

    // Waits the chosen delay, strobes acknowledge once, takes the vector
    always_ff @(posedge clock) begin
        port_ack <= 1'b0;
        if (sys_rst || !ack_en) begin
            wait_cnt <= 4'h0;
            busy <= 1'b0;
            seen <= 1'b0;
        end else if (ack_vector_valid) begin
            last_vec <= ack_vector;
            seen <= 1'b1;
            busy <= 1'b0;
        end else if (port_irq && !busy) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt == ack_delay) begin
                port_ack <= 1'b1;
                busy <= 1'b1;
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule

// >>> bench/tb.sv
// Self-checking bench for the port configuration register block
`timescale 1ns/10ps

module tb import ppc_pkg::*;;
    logic          clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic          port_a_control_svcrq_enable = 1'b0, port_b_control_svcrq_enable = 1'b0;
    logic          handshake_one_transfer = 1'b0, handshake_three_transfer = 1'b0;
    logic          ack_en = 1'b0, pready, pslverr, port_ack, dma_request, port_irq, seen, err;
    logic          ack_vector_valid, port_a_dir_used, port_b_dir_used;
    logic [7:0]    paddr = 8'h00, ack_vector, last_vec, port_a_dir, port_b_dir, port_c_dir;
    logic [31:0]   pwdata = 32'h0, prdata, q;
    logic [3:0]    pstrb = 4'hF, handshake_status = 4'h0, handshake_irq_enable = 4'h0;
    logic [3:0]    handshake_assert = 4'h0, handshake_pin_level = 4'h0, ack_delay = 4'h0;
    logic [3:0]    handshake_pin_out, handshake_pin_asserted;
    ppc_hs_cfg_t   hs_cfg;
    ppc_pin_role_t pin_role;
    int            failures = 0, check_count = 0;

    always #20 clock = ~clock;

    ppc_regs DUT (.*);
    ppc_host_model u_host (.*);

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One APB transfer, waiting for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1 && ++n < 9);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 9) begin
            failures++;
            $display("Error pready expected 1 seen %b", pready);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {24'h0, e}, q);
    endtask

    // Transfer event on line one or three, then the DMA pulse
    task automatic pulse(input logic three, input logic e);
        @(posedge clock);
        {handshake_three_transfer, handshake_one_transfer} <= {three, !three};
        @(posedge clock);
        {handshake_three_transfer, handshake_one_transfer} <= 2'h0;
        @(posedge clock);
        chk("dma", e, dma_request);
    endtask

    task automatic t_reset;
        for (int i = 0; i < 5; i++)
            rd(8'(4 * i), 8'h00);
        rd(8'h14, 8'h0F);
        $display("test reset done");
    endtask

    task automatic t_regs;
        apb(1'b1, 8'h00, 8'hC0);
        apb(1'b1, 8'h00, 8'hF5);
        rd(8'h00, 8'hF5);
        apb(1'b1, 8'h04, 8'hFF);
        rd(8'h04, 8'h7F);
        apb(1'b1, 8'h14, 8'hA6);
        rd(8'h14, 8'hA4);
        for (int i = 2; i < 5; i++) begin
            apb(1'b1, 8'(4 * i), 8'(8'h5A + i));
            rd(8'(4 * i), 8'(8'h5A + i));
        end
        pstrb <= 4'h0;
        apb(1'b1, 8'h10, 8'h00);
        pstrb <= 4'hF;
        rd(8'h10, 8'h5E);
        apb(1'b1, 8'h18, 8'h55);
        chk("pslverr", 1, err);
        rd(8'h18, 8'h00);
        apb(1'b1, 8'h00, 8'h00);
        $display("test registers done");
    endtask

    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 8'h00, {m[1:0], 6'h00});
            repeat (2) @(posedge clock);
            chk("mode", m, hs_cfg.mode);
            chk("a used", m != 3, port_a_dir_used);
            chk("b used", m < 2, port_b_dir_used);
        end
        apb(1'b1, 8'h00, 8'h00);
        $display("test modes done");
    endtask

    task automatic t_pins;
        handshake_assert <= 4'hF;
        handshake_pin_level <= 4'h6;
        for (int e = 0; e < 4; e++) begin
            apb(1'b1, 8'h00, {2'h0, e[1:0], 4'h5});
            repeat (3) @(posedge clock);
            chk("pin out", 16'h569A >> (4 * e) & 4'hF, handshake_pin_out);
        end
        chk("pin in", 4'hC, handshake_pin_asserted);
        $display("test pins done");
    endtask

    task automatic t_svc;
        apb(1'b1, 8'h00, 8'h30);
        port_a_control_svcrq_enable <= 1'b1;
        port_b_control_svcrq_enable <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, 8'h04, {1'b0, s[1:0], s[1:0], 3'h0});
            @(posedge clock);
            chk("dma pin", s[1], pin_role.shared_dma_request_pin_active);
            chk("irq pin", s[0], pin_role.shared_port_irq_pin_active);
            chk("ack pin", s[1], pin_role.shared_port_ack_pin_active);
            pulse(1'b0, s == 2);
            pulse(1'b1, s == 3);
        end
        port_b_control_svcrq_enable <= 1'b0;
        pulse(1'b1, 1'b0);
        $display("test service done");
    endtask

    task automatic t_prio;
        int n;
        handshake_status <= 4'hF;
        for (int p = 0; p < 8; p++) begin
            handshake_irq_enable <= 4'h0;
            apb(1'b1, 8'h04, {3'h0, 2'h3, p[2:0]});
            handshake_irq_enable <= 4'hF;
            ack_delay <= p[0] ? 4'h3 : 4'h0;
            ack_en <= 1'b1;
            n = 0;
            do @(posedge clock); while (seen !== 1'b1 && ++n < 40);
            chk("vector", {6'h29, p[2] ? {1'b1, p[1]} : {1'b0, p[0]}}, last_vec);
            ack_en <= 1'b0;
        end
        $display("test priority done");
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset;
        t_regs;
        t_modes;
        t_pins;
        t_svc;
        t_prio;
        final_report;
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        final_report;
    end
endmodule
